// >>> common/irq_unit_pkg.sv
// Purpose: constants and types for the prioritized vectored interrupt unit
// Assumes: AXI4-Lite register access, 32-bit data, 125 MHz aclk
// Notes:   source index 0 is the highest priority

package irq_unit_pkg;

  localparam int NUM_SRC = 11;

  // Source indices, highest priority first
  localparam int SRC_KEYPAD    = 0;
  localparam int SRC_INTERVAL  = 1;
  localparam int SRC_EXT0      = 2;
  localparam int SRC_EXT1      = 3;
  localparam int SRC_TIMER_A   = 4;
  localparam int SRC_TIMER_B   = 5;
  localparam int SRC_EXT2      = 6;
  localparam int SRC_CARRIER   = 7;
  localparam int SRC_CONVERTER = 8;
  localparam int SRC_SERIAL    = 9;
  localparam int SRC_WATCH     = 10;

  // Vector table
  localparam logic [15:0] VEC_RESET   = 16'hfffe;
  localparam logic [15:0] VEC_FIRST   = 16'hfffc;
  localparam logic [15:0] VEC_STEP    = 16'h0002;
  localparam logic [15:0] VEC_TCALL0  = 16'hffde;

  // Register byte addresses
  localparam logic [7:0] ADDR_ENABLE_HIGH  = 8'h00;
  localparam logic [7:0] ADDR_ENABLE_LOW   = 8'h04;
  localparam logic [7:0] ADDR_REQUEST_HIGH = 8'h08;
  localparam logic [7:0] ADDR_REQUEST_LOW  = 8'h0c;
  localparam logic [7:0] ADDR_EDGE_SELECT  = 8'hd8;
  localparam logic [7:0] ADDR_STATUS_WORD  = 8'h10;
  localparam logic [7:0] ADDR_VECTOR       = 8'h14;
  localparam logic [7:0] ADDR_STACK_PTR    = 8'h18;
  localparam logic [7:0] ADDR_SERIAL_DONE  = 8'h1c;

  // Status word fields
  localparam int PSW_MASTER_BIT = 2;
  localparam int PSW_BREAK_BIT  = 4;

  // Reset values
  localparam logic [7:0] PSW_RESET   = 8'h00;
  localparam logic [7:0] SP_RESET    = 8'hff;
  localparam logic [5:0] EDGE_RESET  = 6'h00;
  localparam logic [15:0] SRC_RESET  = 16'h0000;

  // Edge select codes per line
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // Acceptance timing, aclk stands in for the oscillator
  localparam int ACCEPT_CYCLES   = 8;
  localparam int PUSH_COUNT      = 3;
  localparam logic [8:0] ACC_LAST = 9'(ACCEPT_CYCLES - 1);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_ACCEPT, ST_RETURN} seq_state_e;

  typedef struct packed {
    logic [15:0] ret_addr;
    logic [7:0]  status;
  } stack_frame_s;

endpackage : irq_unit_pkg

// >>> src/prioritized_vectored_interrupt_unit.sv
// Purpose: request latching, masking, priority and acceptance sequencing
// Assumes: core drives instruction boundary and return strobes on aclk
// Notes:   stack frames held locally; one frame per nesting level
//
// What this block does
// - External line edges set three flags in the high request register.
// - Vectoring to an external source clears its flag in hardware.
// - Each external line requests on falling, rising or both edges.
// - Timer match, conversion end and interval overflow set their flags.
// - Serial completion raises serial request and sets serial done flag.
// - Fixed priority, reset at FFFE, key scan FFFC down to watch FFE8.
// - Maskable sources need own enable and master enable at status bit 2.
// - A source with enable bit zero is never accepted.
// - Request flags are readable and writable by software.
// - A request stays pending until accepted or cleared.
// - Acceptance starts after instruction end and takes 8 oscillator periods.
// - Acceptance clears master enable first, blocking following interrupts.
// - Acceptance clears the accepted source's request flag.
// - Return address and status are pushed, stack pointer drops three.
// - Vector address itself is loaded into the counter; no entry address is fetched.
// - With master enable clear no hardware request is accepted, whatever its priority.
// - Break is lowest priority, shares table call zero vector, sets break bit.
// - Simultaneous requests resolve by fixed hardware polling order.
// - The return instruction ends the service task.
// - Edges latch each cycle, poll next; at most twelve cycles to service.
// - Edge selection lives in a register at data address 0D8.

`timescale 1ns/1ns

module prioritized_vectored_interrupt_unit
  import irq_unit_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // External request pins
  input  wire logic        ext_irq_line_zero,
  input  wire logic        ext_irq_line_one,
  input  wire logic        ext_irq_line_two,
  // Peripheral events, one-cycle pulses on aclk
  input  wire logic        keypad_scan_source,
  input  wire logic        interval_timer_overflow,
  input  wire logic        timer_a_match,
  input  wire logic        timer_b_match,
  input  wire logic        carrier_gen_source,
  input  wire logic        converter_done,
  input  wire logic        serial_transfer_done,
  input  wire logic        watch_timer_source,
  // Core handshake
  input  wire logic        instr_boundary,
  input  wire logic        software_break_instr,
  input  wire logic        return_from_irq_instr,
  input  wire logic [15:0] return_addr,
  output logic             accept_busy,
  output logic             vector_load,
  output logic [15:0]      program_counter,
  output logic             return_done,
  output logic             stack_fault
);

  // Registers
  logic [15:0]       src_enable;
  logic [15:0]       src_request;
  logic [5:0]        ext_edge_select_reg;
  logic [7:0]        program_status_word;
  logic [7:0]        stack_ptr;
  logic              serial_done_flag;
  stack_frame_s      frames [0:15];
  seq_state_e        state;
  logic [8:0]        acc_cnt;
  logic [3:0]        acc_src;
  logic              acc_brk;
  logic [15:0]       acc_ret;
  logic [2:0]        sync0;
  logic [2:0]        sync1;
  logic [2:0]        sync2;
  logic [2:0]        ext_level;
  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  // Synchronisers: change counts once second and third stages agree
  wire  [2:0] ext_pins   = {ext_irq_line_two, ext_irq_line_one, ext_irq_line_zero};
  wire  [2:0] ext_stable = ~(sync1 ^ sync2);
  wire  [2:0] ext_rise   = ext_stable & sync2 & ~ext_level;
  wire  [2:0] ext_fall   = ext_stable & ~sync2 & ext_level;
  logic [2:0] ext_edge;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_edge
      wire [1:0] sel = ext_edge_select_reg[2*g +: 2];
      assign ext_edge[g] = (sel == EDGE_FALL) ? ext_fall[g] :
                           (sel == EDGE_RISE) ? ext_rise[g] :
                           (ext_rise[g] | ext_fall[g]);
    end
  endgenerate

  // Hardware set events per source
  wire [15:0] hw_set = {5'h00,
                        watch_timer_source,
                        serial_transfer_done,
                        converter_done,
                        carrier_gen_source,
                        ext_edge[2],
                        timer_b_match,
                        timer_a_match,
                        ext_edge[1],
                        ext_edge[0],
                        interval_timer_overflow,
                        keypad_scan_source};

  // Priority resolution, lowest index wins
  wire        master_en = program_status_word[PSW_MASTER_BIT];
  wire [15:0] eligible  = src_request & src_enable & {16{master_en}};
  logic [3:0] win_idx;
  logic       win_any;

  always_comb
  begin
    win_idx = 4'h0;
    win_any = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (eligible[i])
      begin
        win_idx = 4'(i);
        win_any = 1'b1;
      end
    end
  end

  wire start_hw  = (state == ST_IDLE) && instr_boundary && win_any;
  wire start_brk = (state == ST_IDLE) && software_break_instr && !win_any;
  wire start_acc = start_hw || start_brk;
  wire start_ret = (state == ST_IDLE) && return_from_irq_instr && !start_acc;
  wire acc_end   = (state == ST_ACCEPT) && (acc_cnt == ACC_LAST);
  wire [15:0] acc_clear = (start_hw ? (16'h0001 << win_idx) : 16'h0000);
  wire [15:0] vec_addr  = acc_brk ? VEC_TCALL0 :
                          16'(VEC_FIRST - VEC_STEP * {12'h000, acc_src});
  wire [3:0]  frame_idx = stack_ptr[3:0];

  // Bus decode
  wire        wr_go     = aw_held && w_held && !s_axi_bvalid;
  wire        rd_go     = s_axi_arvalid && !s_axi_rvalid;
  wire        wr_req_hi = wr_go && aw_addr == ADDR_REQUEST_HIGH;
  wire        wr_req_lo = wr_go && aw_addr == ADDR_REQUEST_LOW;
  wire        wr_en_hi  = wr_go && aw_addr == ADDR_ENABLE_HIGH;
  wire        wr_en_lo  = wr_go && aw_addr == ADDR_ENABLE_LOW;
  wire        wr_edge   = wr_go && aw_addr == ADDR_EDGE_SELECT;
  wire        wr_psw    = wr_go && aw_addr == ADDR_STATUS_WORD;
  wire        wr_sdone  = wr_go && aw_addr == ADDR_SERIAL_DONE;
  wire        wr_known  = wr_req_hi | wr_req_lo | wr_en_hi | wr_en_lo | wr_edge | wr_psw | wr_sdone;
  wire        wr_lane   = w_strb[0];
  logic [31:0] rd_mux;
  logic        rd_known;

  always_comb
  begin
    rd_known = 1'b1;
    case (s_axi_araddr)
      ADDR_ENABLE_HIGH:  rd_mux = {24'h000000, src_enable[7:0]};
      ADDR_ENABLE_LOW:   rd_mux = {24'h000000, src_enable[15:8]};
      ADDR_REQUEST_HIGH: rd_mux = {24'h000000, src_request[7:0]};
      ADDR_REQUEST_LOW:  rd_mux = {24'h000000, src_request[15:8]};
      ADDR_EDGE_SELECT:  rd_mux = {26'h0000000, ext_edge_select_reg};
      ADDR_STATUS_WORD:  rd_mux = {24'h000000, program_status_word};
      ADDR_VECTOR:       rd_mux = {16'h0000, program_counter};
      ADDR_STACK_PTR:    rd_mux = {24'h000000, stack_ptr};
      ADDR_SERIAL_DONE:  rd_mux = {31'h00000000, serial_done_flag};
      default:
      begin
        rd_mux   = 32'h00000000;
        rd_known = 1'b0;
      end
    endcase
  end

  // Software writes, then hardware sets win over any clear
  logic [15:0] next_request;

  always_comb
  begin
    next_request = src_request;
    if (wr_req_hi && wr_lane)
      next_request[7:0] = w_data[7:0];
    if (wr_req_lo && wr_lane)
      next_request[15:8] = w_data[7:0];
    next_request = (next_request & ~acc_clear) | hw_set;
  end

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = rd_go;
  assign accept_busy   = (state != ST_IDLE);

  // Handshake and input staging
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      sync0        <= 3'h0;
      sync1        <= 3'h0;
      sync2        <= 3'h0;
      ext_level    <= 3'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
      sync0 <= ext_pins;
      sync1 <= sync0;
      sync2 <= sync1;
      ext_level <= (ext_level & ~ext_stable) | (sync2 & ext_stable);
    end
  end

  // Configuration and flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_enable          <= SRC_RESET;
      src_request         <= SRC_RESET;
      ext_edge_select_reg <= EDGE_RESET;
      serial_done_flag    <= 1'b0;
    end
    else
    begin
      src_request <= next_request;
      if (wr_en_hi && wr_lane)
        src_enable[7:0] <= w_data[7:0];
      if (wr_en_lo && wr_lane)
        src_enable[15:8] <= w_data[7:0];
      if (wr_edge && wr_lane)
        ext_edge_select_reg <= w_data[5:0];
      if (serial_transfer_done)
        serial_done_flag <= 1'b1;
      else if (wr_sdone && wr_lane && !w_data[0])
        serial_done_flag <= 1'b0;
    end
  end

  // Acceptance and return sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state               <= ST_IDLE;
      acc_cnt             <= 9'h000;
      acc_src             <= 4'h0;
      acc_brk             <= 1'b0;
      acc_ret             <= 16'h0000;
      program_status_word <= PSW_RESET;
      stack_ptr           <= SP_RESET;
      program_counter     <= VEC_RESET;
      vector_load         <= 1'b0;
      return_done         <= 1'b0;
      stack_fault         <= 1'b0;
    end
    else
    begin
      vector_load <= 1'b0;
      return_done <= 1'b0;
      if (wr_psw && wr_lane)
        program_status_word <= w_data[7:0];
      case (state)
        ST_IDLE:
        begin
          if (start_acc)
          begin
            state   <= ST_ACCEPT;
            acc_cnt <= 9'h000;
            acc_src <= win_idx;
            acc_brk <= start_brk;
            acc_ret <= return_addr;
            program_status_word[PSW_MASTER_BIT] <= 1'b0;
            if (start_brk)
              program_status_word[PSW_BREAK_BIT] <= 1'b1;
          end
          else if (start_ret)
          begin
            state <= ST_RETURN;
          end
        end
        ST_ACCEPT:
        begin
          acc_cnt <= acc_cnt + 9'h001;
          if (acc_end)
          begin
            // Status pushed with master enable forced back on; a break frame keeps its break bit
            frames[frame_idx] <= '{ret_addr: acc_ret,
                                   status: program_status_word | (8'h01 << PSW_MASTER_BIT)};
            stack_ptr       <= 8'(stack_ptr - 8'(PUSH_COUNT));
            program_counter <= vec_addr;
            vector_load     <= 1'b1;
            state           <= ST_IDLE;
          end
        end
        ST_RETURN:
        begin
          // Shallow frame store: deep nesting wraps; a return on an empty stack flags a fault
          stack_ptr           <= 8'(stack_ptr + 8'(PUSH_COUNT));
          program_status_word <= frames[4'(frame_idx + 4'(PUSH_COUNT))].status;
          program_counter     <= frames[4'(frame_idx + 4'(PUSH_COUNT))].ret_addr;
          stack_fault         <= (stack_ptr == SP_RESET);
          return_done         <= 1'b1;
          state               <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule : prioritized_vectored_interrupt_unit

// >>> verif/irq_unit_monitor.sv
// Purpose: port-level checks on the interrupt unit
// Assumes: one aclk domain, synchronous active-low reset
// Notes:   acceptance length is checked to the exact cycle
`timescale 1ns/1ns

module irq_unit_monitor
  import irq_unit_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus answers
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Core handshake
  input wire logic        instr_boundary,
  input wire logic        return_from_irq_instr,
  input wire logic        accept_busy,
  input wire logic        vector_load,
  input wire logic [15:0] program_counter,
  input wire logic        return_done,
  input wire logic        stack_fault
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_accept_run;
    !vector_load[*8] ##1 vector_load;
  endsequence
  property p_reset_pc;    $rose(aresetn) |-> program_counter == VEC_RESET; endproperty
  property p_accept_time; $rose(accept_busy) && $past(instr_boundary) |-> s_accept_run; endproperty
  property p_vec_pulse;   vector_load |=> !vector_load && $stable(program_counter); endproperty
  property p_vec_busy;    vector_load |-> $past(accept_busy); endproperty
  property p_vec_range;
    vector_load |-> !program_counter[0]
      && ((program_counter >= 16'hffe8 && program_counter <= VEC_FIRST) || program_counter == VEC_TCALL0);
  endproperty
  property p_ret_answer;  return_from_irq_instr && !accept_busy |-> ##[1:2] (return_done || stack_fault); endproperty
  property p_ret_pulse;   return_done |=> !return_done; endproperty
  property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_rdata_hold;  s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_bresp_hold;  s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty

  a_reset_pc : assert property (p_reset_pc) else $error("pc not at reset vector");
  a_accept_time : assert property (p_accept_time) else $error("acceptance length wrong");
  a_vec_pulse : assert property (p_vec_pulse) else $error("vector load not a pulse");
  a_vec_busy : assert property (p_vec_busy) else $error("vector load outside accept");
  a_vec_range : assert property (p_vec_range) else $error("vector outside table");
  a_ret_answer : assert property (p_ret_answer) else $error("return not answered");
  a_ret_pulse : assert property (p_ret_pulse) else $error("return done not a pulse");
  a_read_answer : assert property (p_read_answer) else $error("read not answered");
  a_rdata_hold : assert property (p_rdata_hold) else $error("read data dropped");
  a_bresp_hold : assert property (p_bresp_hold) else $error("write response dropped");
  c_break : cover property (vector_load && program_counter == VEC_TCALL0);
endmodule : irq_unit_monitor

bind prioritized_vectored_interrupt_unit irq_unit_monitor mon (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .instr_boundary, .return_from_irq_instr,
  .accept_busy, .vector_load, .program_counter, .return_done, .stack_fault);

// >>> verif/core_model.sv
// Purpose: behavioural processor core beside the interrupt unit
// Assumes: an instruction ends every fourth aclk cycle while running
// Notes:   break waits for an instruction end, as a real core would
`timescale 1ns/1ns

module core_model
(
  // Clock and reset
  input wire logic         aclk,
  input wire logic         aresetn,
  // Bench commands
  input wire logic         run,
  input wire logic         brk_req,
  input wire logic         ret_req,
  // Interrupt unit side
  input wire logic         accept_busy,
  output logic             instr_boundary,
  output logic             software_break_instr,
  output logic             return_from_irq_instr,
  output logic [15:0]      return_addr
);
  // Only address and status cross; general registers stay with the core
  logic [1:0] step;
  logic       brk_pend;
  wire        at_end = run && !accept_busy && step == 2'h3;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      step                  <= 2'h0;
      brk_pend              <= 1'b0;
      instr_boundary        <= 1'b0;
      software_break_instr  <= 1'b0;
      return_from_irq_instr <= 1'b0;
      return_addr           <= 16'h8000;
    end
    else
    begin
      step                  <= step + 2'h1;
      brk_pend              <= at_end ? 1'b0 : (brk_pend || brk_req);
      instr_boundary        <= at_end;
      software_break_instr  <= at_end && brk_pend;
      return_from_irq_instr <= ret_req && !accept_busy;
      if (at_end)
        return_addr <= return_addr + 16'h0002;
    end
  end
endmodule : core_model

// >>> verif/prioritized_vectored_interrupt_unit_bench.sv
// Purpose: register-level test of the interrupt unit
// Assumes: core model ends an instruction every fourth cycle
// Notes:   acceptance waits are bounded rather than counted exactly
`timescale 1ns/1ns

module prioritized_vectored_interrupt_unit_bench
  import irq_unit_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp, wrsp;
  logic [31:0] s_axi_rdata, rdat;
  logic [7:0]  ev = 8'h00;
  logic        ext0 = 1'b0, ext1 = 1'b1, ext2 = 1'b0;
  logic        run = 1'b0, brk_req = 1'b0, ret_req = 1'b0;
  logic        instr_boundary, software_break_instr, return_from_irq_instr;
  logic [15:0] return_addr, program_counter;
  logic        accept_busy, vector_load, return_done, stack_fault;
  int          n_mismatch = 0;
  int          comparisons = 0;

  initial
  begin
    forever #4 aclk = ~aclk;
  end

  prioritized_vectored_interrupt_unit dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_irq_line_zero(ext0), .ext_irq_line_one(ext1), .ext_irq_line_two(ext2),
    .keypad_scan_source(ev[0]), .interval_timer_overflow(ev[1]), .timer_a_match(ev[2]),
    .timer_b_match(ev[3]), .carrier_gen_source(ev[4]), .converter_done(ev[5]),
    .serial_transfer_done(ev[6]), .watch_timer_source(ev[7]), .instr_boundary,
    .software_break_instr, .return_from_irq_instr, .return_addr, .accept_busy, .vector_load,
    .program_counter, .return_done, .stack_fault);

  core_model core (
    .aclk, .aresetn, .run, .brk_req, .ret_req, .accept_busy, .instr_boundary,
    .software_break_instr, .return_from_irq_instr, .return_addr);

  function automatic logic [31:0] vec(input int idx);
    return 32'(VEC_FIRST - 16'(2 * idx));
  endfunction : vec

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, b, v;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      v  = s_axi_bvalid;
      b  = s_axi_bvalid && s_axi_bready;
      wrsp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (v && !b) s_axi_bready <= 1'b1;
    end
    while (!b);
    s_axi_bready <= 1'b0;
  endtask : wr

  // Ready comes late on purpose so the slave has to hold its answer
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
    bit t, v, r;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      t    = s_axi_arvalid && s_axi_arready;
      v    = s_axi_rvalid;
      r    = s_axi_rvalid && s_axi_rready;
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      @(posedge aclk);
      if (t) s_axi_arvalid <= 1'b0;
      if (v && !r) s_axi_rready <= 1'b1;
    end
    while (!r);
    s_axi_rready <= 1'b0;
    chk(what, rdat, exp);
  endtask : rc

  task automatic wait_evt(input bit for_vec, input string what);
    int n;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (n < 400 && (for_vec ? vector_load : return_done) !== 1'b1);
    chk(what, 32'(n < 400), 32'h1);
    @(posedge aclk);
  endtask : wait_evt

  task automatic ret();
    @(posedge aclk);
    ret_req <= 1'b1;
    @(posedge aclk);
    ret_req <= 1'b0;
    wait_evt(1'b0, "return");
  endtask : ret

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(ADDR_STATUS_WORD, 32'(PSW_RESET), "status");
    rc(ADDR_VECTOR, 32'(VEC_RESET), "vector");
    rc(ADDR_STACK_PTR, 32'(SP_RESET), "stack");
    rc(8'h40, 32'h0, "unmapped");
    chk("unmapped resp", 32'(rrsp), 32'(RESP_SLVERR));
    wr(8'h40, 32'h0);
    chk("unmapped wresp", 32'(wrsp), 32'(RESP_SLVERR));
    $display("test reset done");
    // Fall on line one, rise on line zero, both on line two
    wr(ADDR_EDGE_SELECT, 32'h21);
    @(posedge aclk);
    ev   <= 8'hff;
    ext0 <= 1'b1;
    ext1 <= 1'b0;
    ext2 <= 1'b1;
    @(posedge aclk);
    ev <= 8'h00;
    repeat (10) @(posedge aclk);
    rc(ADDR_REQUEST_HIGH, 32'hff, "request high");
    rc(ADDR_REQUEST_LOW, 32'h07, "request low");
    rc(ADDR_SERIAL_DONE, 32'h1, "serial done");
    wr(ADDR_SERIAL_DONE, 32'h0);
    rc(ADDR_SERIAL_DONE, 32'h0, "serial cleared");
    $display("test flags done");
    wr(ADDR_STATUS_WORD, 32'h04);
    run <= 1'b1;
    repeat (40) @(posedge aclk);
    run <= 1'b0;
    chk("pc masked", 32'(program_counter), 32'(VEC_RESET));
    wr(ADDR_REQUEST_HIGH, 32'h0);
    rc(ADDR_REQUEST_HIGH, 32'h0, "request cleared");
    rc(ADDR_REQUEST_LOW, 32'h07, "request held");
    $display("test masking done");
    wr(ADDR_ENABLE_HIGH, 32'h30);
    wr(ADDR_ENABLE_LOW, 32'h04);
    @(posedge aclk);
    ev <= 8'h0c;
    @(posedge aclk);
    ev  <= 8'h00;
    run <= 1'b1;
    wait_evt(1'b1, "accept");
    run <= 1'b0;
    chk("pc timer a", 32'(program_counter), vec(SRC_TIMER_A));
    rc(ADDR_STATUS_WORD, 32'h00, "master cleared");
    rc(ADDR_REQUEST_HIGH, 32'h20, "flag cleared");
    rc(ADDR_STACK_PTR, 32'hfc, "push");
    run <= 1'b1;
    repeat (40) @(posedge aclk);
    chk("pc held", 32'(program_counter), vec(SRC_TIMER_A));
    // Routine reopens the master enable to allow nesting
    wr(ADDR_STATUS_WORD, 32'h04);
    wait_evt(1'b1, "nested");
    run <= 1'b0;
    chk("pc timer b", 32'(program_counter), vec(SRC_TIMER_B));
    rc(ADDR_STACK_PTR, 32'hf9, "nested push");
    ret();
    rc(ADDR_STACK_PTR, 32'hfc, "pop");
    rc(ADDR_STATUS_WORD, 32'h04, "status restored");
    run <= 1'b1;
    wait_evt(1'b1, "lowest");
    run <= 1'b0;
    chk("pc watch", 32'(program_counter), vec(SRC_WATCH));
    ret();
    ret();
    rc(ADDR_STACK_PTR, 32'hff, "stack empty");
    chk("stack fault", 32'(stack_fault), 32'h0);
    rc(ADDR_REQUEST_LOW, 32'h03, "watch cleared");
    $display("test nesting done");
    brk_req <= 1'b1;
    run     <= 1'b1;
    @(posedge aclk);
    brk_req <= 1'b0;
    wait_evt(1'b1, "break");
    run <= 1'b0;
    chk("pc break", 32'(program_counter), 32'(VEC_TCALL0));
    rc(ADDR_STATUS_WORD, 32'h10, "break bit");
    ret();
    $display("test break done");
    stop_test();
  end

  // Whole run needs about three hundred cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    stop_test();
  end
endmodule : prioritized_vectored_interrupt_unit_bench
